// ### usb_ep0_rx_pkg.sv
/*
 Shared constants for the endpoint 0 receive and stall controller:
 register indices, field positions, token and handshake codes.
 Assumes register byte address = 4 * index on a 32-bit APB.
*/
package usb_ep0_rx_pkg;
   // Register indices (byte address is four times the index)
   localparam logic [7:0] IDX_CFG   = 8'he9;
   localparam logic [7:0] IDX_TXFLG = 8'hec;
   localparam logic [7:0] IDX_DATA  = 8'hed;
   localparam logic [7:0] IDX_COUNT = 8'hee;
   localparam logic [7:0] IDX_FLAGS = 8'hef;
   localparam logic [7:0] IDX_IST   = 8'hf0;
   localparam logic [7:0] IDX_IMASK = 8'hf1;
   // Receive flag fields
   localparam int FLG_ERR    = 5;
   localparam int FLG_OW     = 4;
   localparam int FLG_TOG    = 3;
   localparam int FLG_REFUSE = 2;
   localparam int FLG_STALL  = 1;
   localparam int FLG_FULL   = 0;
   // Control-transfer configuration fields
   localparam int CFG_SEL = 2;
   localparam int CFG_OUT = 1;
   localparam int CFG_IN  = 0;
   // Transmit flag field
   localparam int TXF_STALL = 1;
   // Interrupt status and mask fields
   localparam int INT_SETUP = 0;
   localparam int INT_OUT   = 1;
   localparam int INT_ERR   = 2;
   localparam int INT_W     = 3;
   // FIFO
   localparam int FIFO_DEPTH = 8;
   // Token kinds from the packet decoder
   localparam logic [1:0] TOK_OUT   = 2'h0;
   localparam logic [1:0] TOK_IN    = 2'h1;
   localparam logic [1:0] TOK_SETUP = 2'h2;
   // Handshake codes to the packet encoder
   localparam logic [1:0] HS_NONE  = 2'h0;
   localparam logic [1:0] HS_ACK   = 2'h1;
   localparam logic [1:0] HS_NAK   = 2'h2;
   localparam logic [1:0] HS_STALL = 2'h3;
   typedef enum logic {ST_IDLE, ST_DATA} rx_state_t;
endpackage

// ### usb_ep0_rx_stall.sv
/*
 Endpoint 0 receive path and stall control of a low-speed USB engine,
 with an APB register slave and one level interrupt.
 Assumes the packet decoder and encoder run on clk and deliver
 tokens, data bytes and packet ends as one-cycle pulses.
*/
// What this block does
// [R01] Store received byte count after loading FIFO
// [R02] CRC or stuff error sets error flag
// [R03] Overwrite flag shows SETUP corrupted FIFO
// [R04] Toggle bit follows each good SETUP/OUT except a stalled OUT
// [R05] Refuse clear: accept OUT only when empty
// [R06] Refuse set: NAK OUT tokens unless receive stall is set
// [R07] Receive stall set: STALL OUT tokens
// [R08] Full set by hardware, write one ignored
// [R09] Flags clear on reset and bus reset
// [R10] Toggle select qualifies OUT for auto-stall
// [R11] OUT auto-stall sets both stall bits
// [R12] IN auto-stall sets both stall bits
// [R13] Config clears on resets and SETUP
// [R14] Otherwise OUT clears transmit, IN clears receive
// [R15] Firmware never enables both auto-stalls
// [R16] After ACK: interrupt, store and full in the same cycle
// [R17] Firmware clears full after reading FIFO
// [R18] CPU pops FIFO bytes one by one
// [R19] NAK OUT while FIFO still full
`timescale 1ns/100ps
module usb_ep0_rx_stall
   import usb_ep0_rx_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Packet decoder side
   input  wire logic        usb_bus_reset,
   input  wire logic        tok_valid,
   input  wire logic [1:0]  tok_kind,
   input  wire logic        rx_byte_valid,
   input  wire logic [7:0]  rx_byte,
   input  wire logic        pkt_done,
   input  wire logic        pkt_bad,
   input  wire logic        pkt_toggle,
   // Handshake and status out
   output logic             hs_valid,
   output logic [1:0]       hs_code,
   output logic             pipe0_transmit_stall,
   output logic             irq
);
   typedef struct packed {
      rx_state_t              st;
      logic [7:0][7:0]        fifo;
      logic [3:0]             wr;
      logic [2:0]             rd;
      logic [3:0]             cnt;
      logic                   err;
      logic                   ow;
      logic                   tog;
      logic                   refuse;
      logic                   rx_stall;
      logic                   full;
      logic                   tx_stall;
      logic                   sel;
      logic                   out_auto;
      logic                   in_auto;
      logic                   is_setup;
      logic [1:0]             verdict;
      logic [INT_W-1:0]       ist;
      logic [INT_W-1:0]       imask;
      logic [31:0]            prdata;
      logic                   hs_valid;
      logic [1:0]             hs_code;
   } regs_t;

   regs_t r_reg;
   regs_t r_next;
   logic  rd_setup;
   logic  wr_acc;
   logic  rd_acc;
   logic  mapped;

   function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
      return (a[1:0] == 2'b00) && (a[11:10] == 2'b00) && (a[9:2] == idx);
   endfunction

   assign rd_setup = psel & ~penable & ~pwrite;
   assign wr_acc   = psel & penable & pwrite;
   assign rd_acc   = psel & penable & ~pwrite;
   assign mapped   = hit(paddr, IDX_CFG) | hit(paddr, IDX_TXFLG) | hit(paddr, IDX_DATA)
                   | hit(paddr, IDX_COUNT) | hit(paddr, IDX_FLAGS) | hit(paddr, IDX_IST)
                   | hit(paddr, IDX_IMASK);
   // Zero wait states: read data is latched in the setup cycle
   assign pready   = 1'b1;
   assign pslverr  = psel & penable & ~mapped;
   assign prdata   = r_reg.prdata;
   assign hs_valid = r_reg.hs_valid;
   assign hs_code  = r_reg.hs_code;
   assign pipe0_transmit_stall = r_reg.tx_stall;
   assign irq      = |(r_reg.ist & r_reg.imask);

   always_comb begin
      logic [3:0]  wr_cur;
      logic [31:0] rdata;
      wr_cur = r_reg.wr;
      rdata  = 32'h0000_0000;
      r_next = r_reg;
      r_next.hs_valid = 1'b0;
      r_next.hs_code  = HS_NONE;

      if (hit(paddr, IDX_CFG)) begin
         rdata[CFG_SEL] = r_reg.sel;
         rdata[CFG_OUT] = r_reg.out_auto;
         rdata[CFG_IN]  = r_reg.in_auto;
      end
      if (hit(paddr, IDX_TXFLG)) begin
         rdata[TXF_STALL] = r_reg.tx_stall;
      end
      if (hit(paddr, IDX_DATA)) begin
         rdata[7:0] = r_reg.fifo[r_reg.rd];
      end
      if (hit(paddr, IDX_COUNT)) begin
         rdata[3:0] = r_reg.cnt;
      end
      if (hit(paddr, IDX_FLAGS)) begin
         rdata[FLG_ERR]    = r_reg.err;
         rdata[FLG_OW]     = r_reg.ow;
         rdata[FLG_TOG]    = r_reg.tog;
         rdata[FLG_REFUSE] = r_reg.refuse;
         rdata[FLG_STALL]  = r_reg.rx_stall;
         rdata[FLG_FULL]   = r_reg.full;
      end
      if (hit(paddr, IDX_IST)) begin
         rdata[INT_W-1:0] = r_reg.ist;
      end
      if (hit(paddr, IDX_IMASK)) begin
         rdata[INT_W-1:0] = r_reg.imask;
      end
      if (rd_setup) begin
         r_next.prdata = rdata;
      end

      // Firmware effects first, so that hardware events below win
      if (rd_acc && hit(paddr, IDX_DATA)) begin
         r_next.rd = r_reg.rd + 3'd1; // [R18]
      end
      if (wr_acc) begin
         if (hit(paddr, IDX_CFG)) begin
            r_next.sel      = pwdata[CFG_SEL];
            r_next.out_auto = pwdata[CFG_OUT];
            r_next.in_auto  = pwdata[CFG_IN];
         end
         if (hit(paddr, IDX_TXFLG)) begin
            r_next.tx_stall = pwdata[TXF_STALL];
         end
         if (hit(paddr, IDX_FLAGS)) begin
            if (!pwdata[FLG_ERR]) begin
               r_next.err = 1'b0; // [R02]
            end
            r_next.refuse   = pwdata[FLG_REFUSE];
            r_next.rx_stall = pwdata[FLG_STALL];
            // Clearing full also ends the corrupted state
            if (!pwdata[FLG_FULL]) begin
               r_next.full = 1'b0; // [R08] [R17]
               r_next.ow   = 1'b0; // [R03]
            end
         end
         if (hit(paddr, IDX_IST)) begin
            r_next.ist = r_reg.ist & ~pwdata[INT_W-1:0];
         end
         if (hit(paddr, IDX_IMASK)) begin
            r_next.imask = pwdata[INT_W-1:0];
         end
      end

      unique case (r_reg.st)
         ST_IDLE: begin
            if (tok_valid) begin
               case (tok_kind)
                  TOK_IN: begin
                     if (r_reg.tx_stall) begin
                        r_next.hs_valid = 1'b1;
                        r_next.hs_code  = HS_STALL;
                     end
                     // Both enables set gives the illegal mix on purpose
                     r_next.rx_stall = r_reg.in_auto & ~r_reg.out_auto; // [R12] [R14]
                     if (r_reg.in_auto) begin
                        r_next.tx_stall = 1'b1; // [R12]
                     end
                  end
                  TOK_SETUP: begin
                     // SETUP is never refused and overwrites unread bytes
                     r_next.is_setup = 1'b1;
                     r_next.verdict  = HS_ACK;
                     r_next.wr       = 4'h0;
                     r_next.rd       = 3'h0;
                     if (r_reg.full) begin
                        r_next.ow = 1'b1; // [R03]
                     end
                     r_next.st = ST_DATA;
                  end
                  TOK_OUT: begin
                     r_next.is_setup = 1'b0;
                     if (r_reg.rx_stall) begin
                        r_next.verdict = HS_STALL; // [R07]
                     end else if (r_reg.refuse || r_reg.full) begin
                        r_next.verdict = HS_NAK; // [R06] [R19]
                     end else begin
                        r_next.verdict = HS_ACK; // [R05]
                        r_next.wr      = 4'h0;
                        r_next.rd      = 3'h0;
                     end
                     r_next.st = ST_DATA;
                  end
                  default: ;
               endcase
            end
         end
         ST_DATA: begin
            // Bytes beyond the FIFO depth are dropped
            if (rx_byte_valid && r_reg.verdict == HS_ACK && !r_reg.wr[3]) begin
               r_next.fifo[r_reg.wr[2:0]] = rx_byte;
               wr_cur = r_reg.wr + 4'h1;
               r_next.wr = wr_cur;
            end
            if (pkt_done) begin
               r_next.st = ST_IDLE;
               if (pkt_bad) begin
                  // Corrupt data gets no handshake at all
                  r_next.err = 1'b1; // [R02]
                  r_next.ist[INT_ERR] = 1'b1;
               end else begin
                  r_next.hs_valid = 1'b1;
                  r_next.hs_code  = r_reg.verdict;
                  if (r_reg.verdict != HS_STALL) begin
                     r_next.tog = pkt_toggle; // [R04]
                  end
                  if (r_reg.verdict == HS_ACK) begin
                     r_next.cnt  = wr_cur; // [R01] [R16]
                     r_next.full = 1'b1; // [R08] [R16]
                     if (r_reg.is_setup) begin
                        r_next.ist[INT_SETUP] = 1'b1; // [R16]
                     end else begin
                        r_next.ist[INT_OUT] = 1'b1; // [R16]
                     end
                  end
                  if (r_reg.is_setup) begin
                     r_next.sel      = 1'b0; // [R13]
                     r_next.out_auto = 1'b0;
                     r_next.in_auto  = 1'b0;
                  end else if (r_reg.verdict != HS_STALL) begin
                     if (r_reg.out_auto && (!r_reg.sel || pkt_toggle)) begin
                        r_next.rx_stall = 1'b1; // [R10] [R11]
                        r_next.tx_stall = ~r_reg.in_auto; // [R11]
                     end else begin
                        r_next.tx_stall = 1'b0; // [R14]
                     end
                  end
               end
            end
         end
      endcase

      if (usb_bus_reset) begin
         r_next.st       = ST_IDLE;
         r_next.err      = 1'b0; // [R09]
         r_next.ow       = 1'b0;
         r_next.tog      = 1'b0;
         r_next.refuse   = 1'b0;
         r_next.rx_stall = 1'b0;
         r_next.full     = 1'b0;
         r_next.tx_stall = 1'b0;
         r_next.sel      = 1'b0; // [R13]
         r_next.out_auto = 1'b0;
         r_next.in_auto  = 1'b0;
         r_next.hs_valid = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         r_reg <= '0; // [R09] [R13]
      end else begin
         r_reg <= r_next;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   logic tok_idle;
   assign tok_idle = tok_valid && r_reg.st == ST_IDLE && !usb_bus_reset;

   sequence s_good_done;
      r_reg.st == ST_DATA && pkt_done && !pkt_bad && !usb_bus_reset;
   endsequence

   property p_count;
      s_good_done and (r_reg.verdict == HS_ACK && !rx_byte_valid)
         |=> r_reg.cnt == $past(r_reg.wr) && r_reg.full;
   endproperty
   a_count: assert property (p_count) else $error("count not stored"); // [R01]

   property p_err;
      (r_reg.st == ST_DATA && pkt_done && pkt_bad && !usb_bus_reset) |=> r_reg.err && !hs_valid;
   endproperty
   a_err: assert property (p_err) else $error("bad packet mishandled"); // [R02]

   property p_ow;
      (tok_idle && tok_kind == TOK_SETUP && r_reg.full) |=> r_reg.ow;
   endproperty
   a_ow: assert property (p_ow) else $error("overwrite flag missing"); // [R03]

   property p_tog;
      s_good_done and (r_reg.verdict != HS_STALL) |=> r_reg.tog == $past(pkt_toggle);
   endproperty
   a_tog: assert property (p_tog) else $error("toggle not updated"); // [R04]

   property p_accept;
      (tok_idle && tok_kind == TOK_OUT && !r_reg.rx_stall && !r_reg.refuse && !r_reg.full)
         |=> r_reg.verdict == HS_ACK && r_reg.st == ST_DATA && r_reg.wr == 4'h0;
   endproperty
   a_accept: assert property (p_accept) else $error("OUT not accepted"); // [R05]
   property p_nak;
      (tok_idle && tok_kind == TOK_OUT && !r_reg.rx_stall && (r_reg.refuse || r_reg.full))
         |=> r_reg.verdict == HS_NAK && r_reg.st == ST_DATA;
   endproperty
   a_nak: assert property (p_nak) else $error("OUT not refused"); // [R06] [R19]

   property p_stall;
      (tok_idle && tok_kind == TOK_OUT && r_reg.rx_stall) |=> r_reg.verdict == HS_STALL;
   endproperty
   a_stall: assert property (p_stall) else $error("OUT not stalled"); // [R07]

   property p_full_hold;
      (r_reg.full && !usb_bus_reset && wr_acc && hit(paddr, IDX_FLAGS) && pwdata[FLG_FULL])
         |=> r_reg.full;
   endproperty
   a_full_hold: assert property (p_full_hold) else $error("full lost on write one"); // [R08]

   property p_bus_reset;
      usb_bus_reset |=> !r_reg.err && !r_reg.full && !r_reg.rx_stall && !r_reg.tx_stall
         && !r_reg.sel && !r_reg.out_auto && !r_reg.in_auto;
   endproperty
   a_bus_reset: assert property (p_bus_reset) else $error("bus reset incomplete"); // [R09] [R13]

   property p_auto_out;
      s_good_done and (!r_reg.is_setup && r_reg.verdict != HS_STALL && r_reg.out_auto
         && !r_reg.in_auto && (!r_reg.sel || pkt_toggle)) |=> r_reg.tx_stall && r_reg.rx_stall;
   endproperty
   a_auto_out: assert property (p_auto_out) else $error("OUT auto-stall missing"); // [R10] [R11]

   property p_auto_in;
      (tok_idle && tok_kind == TOK_IN && r_reg.in_auto && !r_reg.out_auto)
         |=> r_reg.tx_stall && r_reg.rx_stall;
   endproperty
   a_auto_in: assert property (p_auto_in) else $error("IN auto-stall missing"); // [R12]

   property p_in_clear;
      (tok_idle && tok_kind == TOK_IN && !r_reg.in_auto) |=> !r_reg.rx_stall;
   endproperty
   a_in_clear: assert property (p_in_clear) else $error("IN did not clear stall"); // [R14]
endmodule // usb_ep0_rx_stall

// ### usb_host_model.sv
/*
 Low-speed host seen through the packet decoder: tokens, data bytes,
 packet ends and bus reset. Assumes the same clk as the block.
*/
`timescale 1ns/100ps
module usb_host_model
   import usb_ep0_rx_pkg::*;
(
   // Clock
   input  wire logic       clk,
   // Decoder outputs
   output logic            usb_bus_reset,
   output logic            tok_valid,
   output logic [1:0]      tok_kind,
   output logic            rx_byte_valid,
   output logic [7:0]      rx_byte,
   output logic            pkt_done,
   output logic            pkt_bad,
   output logic            pkt_toggle
);
   initial begin
      usb_bus_reset = 0;
      tok_valid = 0;
      tok_kind = 2'h3;
      rx_byte_valid = 0;
      rx_byte = 8'h00;
      pkt_done = 0;
      pkt_bad = 0;
      pkt_toggle = 0;
   end

   // Byte values are 8'h5a upward; released lines flip so stale data is not reusable
   task automatic send(input logic [1:0] kind, input int n, input logic tog, input logic bad);
      @(posedge clk);
      tok_valid <= 1;
      tok_kind <= kind;
      @(posedge clk);
      tok_valid <= 0;
      tok_kind <= 2'h3;
      if (kind != TOK_IN) begin
         for (int i = 0; i < n; i++) begin
            rx_byte_valid <= 1;
            rx_byte <= 8'h5a + i[7:0];
            @(posedge clk);
         end
         rx_byte_valid <= 0;
         rx_byte <= ~rx_byte;
         pkt_done <= 1;
         pkt_bad <= bad;
         pkt_toggle <= tog;
         @(posedge clk);
         pkt_done <= 0;
         pkt_bad <= ~bad;
         pkt_toggle <= ~tog;
      end
   endtask

   task automatic bus_reset();
      @(posedge clk);
      usb_bus_reset <= 1;
      repeat (2) @(posedge clk);
      usb_bus_reset <= 0;
      @(posedge clk);
   endtask
endmodule // usb_host_model

// ### usb_ep0_receive_stall_ctrl_test.sv
/*
 Self-checking bench for the endpoint 0 receive and stall block.
 Assumes zero-wait APB answers and handshakes two edges after a packet.
*/
`timescale 1ns/100ps
module usb_ep0_receive_stall_ctrl_test
   import usb_ep0_rx_pkg::*;
();
   logic        clk, sys_rst, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, er;
   logic        usb_bus_reset, tok_valid, rx_byte_valid, pkt_done, pkt_bad, pkt_toggle;
   logic [1:0]  tok_kind, hs_code, hs_last;
   logic [7:0]  rx_byte;
   logic        hs_valid, pipe0_transmit_stall, irq;
   int          num_errors = 0;
   int          cmp_count = 0;

   usb_ep0_rx_stall i_usb_ep0_rx_stall (.clk(clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .usb_bus_reset(usb_bus_reset),
      .tok_valid(tok_valid), .tok_kind(tok_kind), .rx_byte_valid(rx_byte_valid),
      .rx_byte(rx_byte), .pkt_done(pkt_done), .pkt_bad(pkt_bad), .pkt_toggle(pkt_toggle),
      .hs_valid(hs_valid), .hs_code(hs_code),
      .pipe0_transmit_stall(pipe0_transmit_stall), .irq(irq));

   usb_host_model i_usb_host_model (.clk(clk), .usb_bus_reset(usb_bus_reset),
      .tok_valid(tok_valid), .tok_kind(tok_kind), .rx_byte_valid(rx_byte_valid),
      .rx_byte(rx_byte), .pkt_done(pkt_done), .pkt_bad(pkt_bad), .pkt_toggle(pkt_toggle));

   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) if (hs_valid === 1'b1) hs_last <= hs_code;

   task automatic test_done();
      if (num_errors == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic chk_hs(input logic [1:0] g, input logic [1:0] e);
      chk_reg({30'h0, g}, {30'h0, e});
   endtask

   // Bounded wait for pready; a hang ends the run as a failure
   task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
      int n;
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= wd;
      @(posedge clk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         num_errors++;
         test_done();
      end
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask

   // Let the written register settle before any output is looked at
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      apb(1, idx, d);
      @(negedge clk);
   endtask

   task automatic rdc(input logic [7:0] idx, input logic [31:0] e);
      apb(0, idx, 32'h0);
      chk_reg(rd, e);
   endtask

   task automatic pkt(input logic [1:0] k, input int n, input logic t, input logic b,
                      input logic [1:0] e);
      hs_last = HS_NONE;
      i_usb_host_model.send(k, n, t, b);
      repeat (2) @(posedge clk);
      chk_hs(hs_last, e);
   endtask

   task automatic t_reset();
      rdc(IDX_FLAGS, 32'h0);
      rdc(IDX_CFG, 32'h0);
      apb(0, 8'h10, 32'h0);
      chk_reg({31'h0, er}, 32'h1);
   endtask

   task automatic t_out();
      pkt(TOK_OUT, 3, 1, 0, HS_ACK);
      rdc(IDX_FLAGS, 32'h09);
      rdc(IDX_COUNT, 32'h3);
      rdc(IDX_IST, 32'h2);
      chk_reg({31'h0, irq}, 32'h0);
      wr(IDX_IMASK, 32'h2);
      chk_reg({31'h0, irq}, 32'h1);
      pkt(TOK_OUT, 2, 1, 0, HS_NAK);
      rdc(IDX_COUNT, 32'h3);
      for (int i = 0; i < 3; i++) rdc(IDX_DATA, 32'h5a + i);
      wr(IDX_FLAGS, 32'h1);
      rdc(IDX_FLAGS, 32'h09);
      wr(IDX_IST, 32'h2);
      chk_reg({31'h0, irq}, 32'h0);
      wr(IDX_FLAGS, 32'h0);
      rdc(IDX_FLAGS, 32'h08);
   endtask

   task automatic t_err();
      pkt(TOK_OUT, 2, 0, 1, HS_NONE);
      rdc(IDX_FLAGS, 32'h28);
      wr(IDX_FLAGS, 32'h20);
      rdc(IDX_FLAGS, 32'h28);
      wr(IDX_FLAGS, 32'h0);
      rdc(IDX_FLAGS, 32'h08);
      wr(IDX_FLAGS, 32'h4);
      pkt(TOK_OUT, 1, 1, 0, HS_NAK);
      wr(IDX_FLAGS, 32'h2);
      pkt(TOK_OUT, 1, 1, 0, HS_STALL);
      wr(IDX_FLAGS, 32'h0);
      rdc(IDX_FLAGS, 32'h08);
   endtask

   // Both auto-stall enables are never set together
   task automatic t_auto();
      wr(IDX_CFG, 32'h6);
      wr(IDX_TXFLG, 32'h2);
      pkt(TOK_OUT, 1, 0, 0, HS_ACK);
      chk_reg({31'h0, pipe0_transmit_stall}, 32'h0);
      rdc(IDX_FLAGS, 32'h01);
      wr(IDX_FLAGS, 32'h0);
      pkt(TOK_OUT, 1, 1, 0, HS_ACK);
      chk_reg({31'h0, pipe0_transmit_stall}, 32'h1);
      rdc(IDX_FLAGS, 32'h0b);
      wr(IDX_CFG, 32'h1);
      wr(IDX_FLAGS, 32'h0);
      wr(IDX_TXFLG, 32'h0);
      pkt(TOK_IN, 0, 0, 0, HS_NONE);
      chk_reg({31'h0, pipe0_transmit_stall}, 32'h1);
      rdc(IDX_FLAGS, 32'h0a);
      pkt(TOK_IN, 0, 0, 0, HS_STALL);
      rdc(IDX_FLAGS, 32'h0a);
      wr(IDX_CFG, 32'h0);
      wr(IDX_TXFLG, 32'h0);
      pkt(TOK_IN, 0, 0, 0, HS_NONE);
      rdc(IDX_FLAGS, 32'h08);
   endtask

   task automatic t_setup();
      pkt(TOK_OUT, 2, 1, 0, HS_ACK);
      wr(IDX_CFG, 32'h6);
      pkt(TOK_SETUP, 8, 0, 0, HS_ACK);
      rdc(IDX_FLAGS, 32'h11);
      rdc(IDX_CFG, 32'h0);
      rdc(IDX_COUNT, 32'h8);
      wr(IDX_FLAGS, 32'h0);
      rdc(IDX_FLAGS, 32'h0);
      wr(IDX_FLAGS, 32'h6);
      wr(IDX_CFG, 32'h4);
      i_usb_host_model.bus_reset();
      rdc(IDX_FLAGS, 32'h0);
      rdc(IDX_CFG, 32'h0);
   endtask

   initial begin
      sys_rst = 1;
      psel = 0;
      penable = 0;
      pwrite = 0;
      paddr = 12'h000;
      pwdata = 32'h0;
      hs_last = HS_NONE;
      repeat (6) @(posedge clk);
      sys_rst <= 0;
      t_reset();
      t_out();
      t_err();
      t_auto();
      t_setup();
      test_done();
   end
endmodule // usb_ep0_receive_stall_ctrl_test
